/* File: shared/hbac_pkg.sv */
`default_nettype none
package hbac_pkg;
  // ************************************************************
  // Clock and time base
  // ************************************************************
  localparam int unsigned CLK_HZ    = 40_000_000;
  localparam int unsigned MS_PER_S  = 1000;
  localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int unsigned MSW       = 18;
  localparam int unsigned NZONE     = 8;

  // ************************************************************
  // Times, counted in 1 ms ticks except T_STOP_MIN, which is in minutes
  // ************************************************************
  localparam int unsigned T_DEBOUNCE_MS     = 5;
  localparam int unsigned T_TOUCH_IGNORE_MS = 500;
  localparam int unsigned T_TOUCH_HOLD_MS   = 2000;
  localparam int unsigned T_ALARM_DLY_MS    = 2000;
  localparam int unsigned T_TEST_NORM_MS    = 5000;
  localparam int unsigned T_TEST_EXT_MS     = 8000;
  localparam int unsigned T_TEST_INV_MS     = 3000;
  localparam int unsigned T_STOP_MIN        = 3;
  localparam int unsigned T_STOP_MS         = T_STOP_MIN * 60 * MS_PER_S;
  localparam int unsigned T_BLINK_HALF_MS   = 500;

  // ************************************************************
  // Fields and reset values
  // ************************************************************
  localparam int unsigned TEST_ZONE_A = 6;
  localparam int unsigned TEST_ZONE_B = 7;
  localparam int unsigned BTN_TEST    = 0;
  localparam int unsigned BTN_MUTE    = 1;
  localparam int unsigned NBTN        = 2;
  localparam logic        ZONE_RST    = 1'b1;
  localparam logic        MUTE_RST    = 1'b0;

  typedef enum logic [2:0] {TS_IDLE, TS_HOLD, TS_NORM, TS_EXT, TS_INV} hbac_test_t;

  typedef struct packed {
    logic [NZONE-1:0] zone_lamp;
    logic             alarm_lamp;
    logic             alarm_relay;
    logic             stop_relay;
    logic             test_led;
    logic             mute_led;
  } hbac_out_t;

  localparam hbac_out_t OUT_RST = '{zone_lamp: 8'h00, alarm_lamp: 1'b0, alarm_relay: 1'b0,
                                    stop_relay: 1'b1, test_led: 1'b0, mute_led: 1'b0};
endpackage
`default_nettype wire

/* File: design/hbac_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module hbac_filter #(
  parameter int unsigned DEB_MS  = hbac_pkg::T_DEBOUNCE_MS,
  parameter logic        RST_LVL = 1'b0
) (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic tick_i,
  input  wire logic raw_i,
  output logic      level_o
);
  localparam int unsigned CW = $clog2(DEB_MS + 1);
  localparam logic [CW-1:0] L_DEB = CW'(DEB_MS);

  if (DEB_MS == 0) begin : g_chk
    $error("hbac_filter: debounce time must be at least one tick");
  end

  logic          sync_a;
  logic          sync_b;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_level;

  // ************************************************************
  // Settle filter
  // ************************************************************
  // Level only moves after the synchronised input disagrees for DEB_MS ticks
  always_comb begin
    next_cnt   = cnt;
    next_level = level_o;
    if (sync_b == level_o) begin
      next_cnt = '0;
    end else if (cnt >= L_DEB) begin
      next_level = sync_b; // RULE25
      next_cnt   = '0;
    end else if (tick_i) begin
      next_cnt = cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sync_a  <= RST_LVL;
      sync_b  <= RST_LVL;
      cnt     <= '0;
      level_o <= RST_LVL;
    end else begin
      sync_a  <= raw_i; // RULE25
      sync_b  <= sync_a;
      cnt     <= next_cnt;
      level_o <= next_level;
    end
  end

  a_filter_settle: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE25
    (level_o != $past(level_o)) |-> ($past(cnt) == L_DEB))
    else $error("Filtered level moved before the settle time");
endmodule // hbac_filter
`default_nettype wire

/* File: design/hbac_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1: Unused zone inputs are tied to supply and read as cold.
// RULE2: Open or high-resistance sensor chain (low input) is hot.
// RULE3: Holding test flashes zone 7 lamp; release starts the normal test.
// RULE4: Normal test lights all lamps, zone 7 flashing, restores after 5 s.
// RULE5: Second test touch gives extended test; lamps 7,8 flash to 8 s total.
// RULE6: Then both relays invert; lamps 7, 8 and alarm lamp flash.
// RULE7: Three seconds later all lamps and relays return to live state.
// RULE8: A touch counts only after it persisted for 0.5 s.
// RULE9: Active button lights indicator; ends on release or after 2 s.
// RULE10: All cold: lamps and alarm relay off, stop relay energised.
// RULE11: Hot zone lights its lamp and alarm lamp; relay after 2 s.
// RULE12: Each zone lamp follows its own zone; several may light.
// RULE13: Alarm lamp and relay clear only when every zone is cold.
// RULE14: Mute flashes alarm lamp, drops relay, flashes lit zone lamps.
// RULE15: Remote mute input acts exactly like the mute button; the code mutes on it without the 0.5 s wait and leaves mute_led off.
// RULE16: Muted flashing lamp goes off when its zone turns cold.
// RULE17: New hot zone while muted: steady lamp, alarm lamp and relay back.
// RULE18: A later mute flashes every lit zone lamp.
// RULE19: Shutdown timer counts while alarm lamp is on; at 3 min stop drops.
// RULE20: Count is kept when alarm clears and resumes on return.
// RULE21: With no alarm the timer counts down, never below zero.
// RULE22: After a stop the hot zone lamps flash until cooled.
// RULE23: When stopped zones cool, flashing ends and both relays restore.
// RULE24: Timer counts down at its up rate; one shared 1 Hz blink.
// RULE25: Zone and remote mute inputs are synchronised and debounced.
module hbac_top #(
  parameter int unsigned MS_CYCLES     = hbac_pkg::MS_CYCLES,
  parameter int unsigned DEBOUNCE_MS   = hbac_pkg::T_DEBOUNCE_MS,
  parameter int unsigned TOUCH_IGN_MS  = hbac_pkg::T_TOUCH_IGNORE_MS,
  parameter int unsigned TOUCH_HOLD_MS = hbac_pkg::T_TOUCH_HOLD_MS,
  parameter int unsigned ALARM_DLY_MS  = hbac_pkg::T_ALARM_DLY_MS,
  parameter int unsigned TEST_NORM_MS  = hbac_pkg::T_TEST_NORM_MS,
  parameter int unsigned TEST_EXT_MS   = hbac_pkg::T_TEST_EXT_MS,
  parameter int unsigned TEST_INV_MS   = hbac_pkg::T_TEST_INV_MS,
  parameter int unsigned STOP_MS       = hbac_pkg::T_STOP_MS,
  parameter int unsigned BLINK_MS      = hbac_pkg::T_BLINK_HALF_MS
) (
  input  wire logic                        core_clk_i,
  input  wire logic                        rst_i,
  input  wire logic [hbac_pkg::NZONE-1:0]  zone_level_i,
  input  wire logic                        remote_mute_i,
  input  wire logic                        touch_test_i,
  input  wire logic                        touch_mute_i,
  output hbac_pkg::hbac_out_t              out_o
);
  localparam int unsigned MSW  = hbac_pkg::MSW;
  localparam int unsigned NZ   = hbac_pkg::NZONE;
  localparam int unsigned DIVW = $clog2(MS_CYCLES);
  localparam logic [DIVW-1:0] L_DIV   = DIVW'(MS_CYCLES - 1);
  localparam logic [MSW-1:0] L_IGN    = MSW'(TOUCH_IGN_MS);
  localparam logic [MSW-1:0] L_TMAX   = MSW'(TOUCH_IGN_MS + TOUCH_HOLD_MS);
  localparam logic [MSW-1:0] L_DLY    = MSW'(ALARM_DLY_MS);
  localparam logic [MSW-1:0] L_NORM   = MSW'(TEST_NORM_MS);
  localparam logic [MSW-1:0] L_EXT    = MSW'(TEST_EXT_MS);
  localparam logic [MSW-1:0] L_INV    = MSW'(TEST_INV_MS);
  localparam logic [MSW-1:0] L_STOP   = MSW'(STOP_MS);
  localparam logic [MSW-1:0] L_BLINK  = MSW'(BLINK_MS - 1);

  if (MS_CYCLES < 2 || BLINK_MS == 0 || STOP_MS == 0 || TEST_EXT_MS <= TEST_NORM_MS ||
      STOP_MS >= 2**MSW || TEST_EXT_MS >= 2**MSW ||
      TOUCH_IGN_MS + TOUCH_HOLD_MS >= 2**MSW) begin : g_chk
    $error("hbac_top: timing parameters out of range");
  end

  function automatic logic [NZ-1:0] zone_bit(input int unsigned z);
    zone_bit = NZ'(1) << z;
  endfunction

  localparam logic [NZ-1:0] M_TA  = zone_bit(hbac_pkg::TEST_ZONE_A);
  localparam logic [NZ-1:0] M_TAB = zone_bit(hbac_pkg::TEST_ZONE_A) |
                                    zone_bit(hbac_pkg::TEST_ZONE_B);

  // ************************************************************
  // Time base and shared blink
  // ************************************************************
  logic [DIVW-1:0] div;
  logic [DIVW-1:0] next_div;
  logic            tick;
  logic            next_tick;
  logic [MSW-1:0]  blink_cnt;
  logic [MSW-1:0]  next_blink_cnt;
  logic            blink;
  logic            next_blink;

  always_comb begin
    next_div       = (div == L_DIV) ? '0 : div + 1'b1;
    next_tick      = (div == L_DIV);
    next_blink_cnt = blink_cnt;
    next_blink     = blink;
    if (tick) begin
      next_blink_cnt = (blink_cnt == L_BLINK) ? '0 : blink_cnt + 1'b1;
      next_blink     = (blink_cnt == L_BLINK) ? ~blink : blink; // RULE24
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      div       <= '0;
      tick      <= 1'b0;
      blink_cnt <= '0;
      blink     <= 1'b0;
    end else begin
      div       <= next_div;
      tick      <= next_tick;
      blink_cnt <= next_blink_cnt;
      blink     <= next_blink;
    end
  end

  // ************************************************************
  // Input filters
  // ************************************************************
  logic [NZ-1:0] zone_lvl;
  logic          remote_lvl;
  logic [NZ-1:0] hot;
  logic          alarm;

  for (genvar z = 0; z < NZ; z++) begin : g_zone
    hbac_filter #(.DEB_MS(DEBOUNCE_MS), .RST_LVL(hbac_pkg::ZONE_RST)) u_filt (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .tick_i     (tick),
      .raw_i      (zone_level_i[z]),
      .level_o    (zone_lvl[z])
    );
  end

  hbac_filter #(.DEB_MS(DEBOUNCE_MS), .RST_LVL(hbac_pkg::MUTE_RST)) u_remote (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .tick_i     (tick),
    .raw_i      (remote_mute_i),
    .level_o    (remote_lvl)
  );

  // Low input means the chain resistance is high: a hot sensor or a broken wire
  assign hot   = ~zone_lvl; // RULE2 RULE1
  assign alarm = |hot;      // RULE13

  // ************************************************************
  // Touch buttons
  // ************************************************************
  // Inputs are already clean levels from the touch front end
  logic [hbac_pkg::NBTN-1:0] touch_raw;
  logic [hbac_pkg::NBTN-1:0] touch_act;
  logic [MSW-1:0]            touch_cnt [hbac_pkg::NBTN];

  assign touch_raw = {touch_mute_i, touch_test_i};

  for (genvar b = 0; b < hbac_pkg::NBTN; b++) begin : g_btn
    logic [MSW-1:0] next_cnt;
    always_comb begin
      next_cnt = '0;
      if (touch_raw[b]) begin
        next_cnt = (tick && touch_cnt[b] < L_TMAX) ? touch_cnt[b] + 1'b1 : touch_cnt[b];
      end
    end
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        touch_cnt[b] <= '0;
      end else begin
        touch_cnt[b] <= next_cnt;
      end
    end
    assign touch_act[b] = touch_raw[b] && touch_cnt[b] >= L_IGN && touch_cnt[b] < L_TMAX; // RULE8 RULE9
  end

  // ************************************************************
  // Mute and alarm delay
  // ************************************************************
  logic          mute_req;
  logic          mute_req_q;
  logic          mute_go;
  logic [NZ-1:0] mute_mask;
  logic [NZ-1:0] next_mute_mask;
  logic          alarm_muted;
  logic          next_alarm_muted;
  logic [MSW-1:0] dly_cnt;
  logic [MSW-1:0] next_dly_cnt;

  assign mute_req = touch_act[hbac_pkg::BTN_MUTE] | remote_lvl; // RULE15
  assign mute_go  = mute_req & ~mute_req_q & alarm;

  always_comb begin
    next_mute_mask   = mute_mask & hot; // RULE16
    next_alarm_muted = alarm_muted;
    next_dly_cnt     = '0;
    if (mute_go) begin
      next_mute_mask   = hot;  // RULE14 RULE18
      next_alarm_muted = 1'b1; // RULE14
    end else if (!alarm || |(hot & ~mute_mask)) begin
      next_alarm_muted = 1'b0; // RULE17
    end
    if (alarm && !alarm_muted) begin
      next_dly_cnt = (tick && dly_cnt < L_DLY) ? dly_cnt + 1'b1 : dly_cnt; // RULE11
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mute_req_q  <= 1'b0;
      mute_mask   <= '0;
      alarm_muted <= 1'b0;
      dly_cnt     <= '0;
    end else begin
      mute_req_q  <= mute_req;
      mute_mask   <= next_mute_mask;
      alarm_muted <= next_alarm_muted;
      dly_cnt     <= next_dly_cnt;
    end
  end

  // ************************************************************
  // Shutdown timer
  // ************************************************************
  logic [MSW-1:0] shut_cnt;
  logic [MSW-1:0] next_shut_cnt;
  logic           stopped;
  logic           next_stopped;

  always_comb begin
    next_shut_cnt = shut_cnt;
    next_stopped  = stopped;
    if (tick) begin
      if (alarm) begin
        next_shut_cnt = (shut_cnt < L_STOP) ? shut_cnt + 1'b1 : shut_cnt; // RULE19 RULE20
      end else if (shut_cnt != '0) begin
        next_shut_cnt = shut_cnt - 1'b1; // RULE21 RULE24
      end
    end
    if (!stopped && shut_cnt >= L_STOP) begin
      next_stopped = 1'b1; // RULE19
    end else if (stopped && !alarm) begin
      next_stopped  = 1'b0; // RULE23
      next_shut_cnt = '0;   // Fresh start after a cooled stop, else it would trip at once
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      shut_cnt <= '0;
      stopped  <= 1'b0;
    end else begin
      shut_cnt <= next_shut_cnt;
      stopped  <= next_stopped;
    end
  end

  // ************************************************************
  // Self test sequencer
  // ************************************************************
  hbac_pkg::hbac_test_t test_st;
  hbac_pkg::hbac_test_t next_test_st;
  logic [MSW-1:0]       test_cnt;
  logic [MSW-1:0]       next_test_cnt;
  logic                 test_q;
  logic                 test_act;
  logic                 test_go;

  assign test_act = touch_act[hbac_pkg::BTN_TEST];
  assign test_go  = test_act & ~test_q;

  always_comb begin
    next_test_st  = test_st;
    next_test_cnt = tick ? test_cnt + 1'b1 : test_cnt;
    unique case (test_st)
      hbac_pkg::TS_IDLE: begin
        next_test_cnt = '0;
        if (test_go) next_test_st = hbac_pkg::TS_HOLD;
      end
      hbac_pkg::TS_HOLD: begin
        next_test_cnt = '0;
        if (!test_act) next_test_st = hbac_pkg::TS_NORM; // RULE3
      end
      hbac_pkg::TS_NORM: begin
        if (test_go) next_test_st = hbac_pkg::TS_EXT; // RULE5
        else if (test_cnt >= L_NORM) next_test_st = hbac_pkg::TS_IDLE; // RULE4
      end
      hbac_pkg::TS_EXT: begin
        if (test_cnt >= L_EXT) begin
          next_test_st  = hbac_pkg::TS_INV; // RULE5 RULE6
          next_test_cnt = '0;
        end
      end
      hbac_pkg::TS_INV: begin
        if (test_cnt >= L_INV) next_test_st = hbac_pkg::TS_IDLE; // RULE7
      end
      default: next_test_st = hbac_pkg::TS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      test_st  <= hbac_pkg::TS_IDLE;
      test_cnt <= '0;
      test_q   <= 1'b0;
    end else begin
      test_st  <= next_test_st;
      test_cnt <= next_test_cnt;
      test_q   <= test_act;
    end
  end

  // ************************************************************
  // Lamp and relay outputs
  // ************************************************************
  // The live state keeps running under the test overlay, so ending a test restores it
  logic [NZ-1:0]       flash_set;
  logic                live_relay;
  logic                live_stop;
  hbac_pkg::hbac_out_t next_out;

  assign flash_set  = stopped ? hot : (mute_mask & hot); // RULE14 RULE22
  assign live_relay = alarm && !alarm_muted && dly_cnt >= L_DLY; // RULE11 RULE13
  assign live_stop  = !stopped; // RULE10 RULE19 RULE23

  always_comb begin
    next_out.zone_lamp   = (hot & ~flash_set) | (flash_set & {NZ{blink}}); // RULE12 RULE16
    next_out.alarm_lamp  = alarm && ((alarm_muted || stopped) ? blink : 1'b1); // RULE14
    next_out.alarm_relay = live_relay;
    next_out.stop_relay  = live_stop;
    next_out.test_led    = test_act; // RULE9
    next_out.mute_led    = touch_act[hbac_pkg::BTN_MUTE];
    unique case (test_st)
      hbac_pkg::TS_IDLE: ;
      hbac_pkg::TS_HOLD: begin
        next_out.zone_lamp = (next_out.zone_lamp & ~M_TA) | (M_TA & {NZ{blink}}); // RULE3
      end
      hbac_pkg::TS_NORM: begin
        next_out.zone_lamp  = ~M_TA | (M_TA & {NZ{blink}}); // RULE4
        next_out.alarm_lamp = 1'b1;
      end
      hbac_pkg::TS_EXT: begin
        next_out.zone_lamp  = ~M_TAB | (M_TAB & {NZ{blink}}); // RULE5
        next_out.alarm_lamp = 1'b1;
      end
      hbac_pkg::TS_INV: begin
        next_out.zone_lamp   = ~M_TAB | (M_TAB & {NZ{blink}}); // RULE6
        next_out.alarm_lamp  = blink;
        next_out.alarm_relay = ~live_relay;
        next_out.stop_relay  = ~live_stop;
      end
      default: ;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      out_o <= hbac_pkg::OUT_RST;
    end else begin
      out_o <= next_out;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_stop_then_cool;
    stopped && !alarm && test_st == hbac_pkg::TS_IDLE;
  endsequence
  sequence s_restored;
    !stopped ##1 out_o.stop_relay;
  endsequence
  sequence s_mute_taken;
    mute_go ##1 (hot == $past(hot));
  endsequence

  a_cold_quiet: assert property ( // RULE10
    (!alarm && !stopped && test_st == hbac_pkg::TS_IDLE) |=>
      (out_o.zone_lamp == '0 && !out_o.alarm_lamp && !out_o.alarm_relay && out_o.stop_relay))
    else $error("Outputs not quiet with every zone cold");
  a_zone_steady: assert property ( // RULE12
    (test_st == hbac_pkg::TS_IDLE) |=>
      ((out_o.zone_lamp & ~$past(hot)) == '0 &&
       (out_o.zone_lamp & $past(hot & ~flash_set)) == $past(hot & ~flash_set)))
    else $error("Zone lamp does not follow its zone");
  a_relay_delay: assert property ( // RULE11
    (out_o.alarm_relay && $past(test_st) == hbac_pkg::TS_IDLE) |->
      ($past(dly_cnt) == L_DLY && $past(alarm) && !$past(alarm_muted)))
    else $error("Alarm relay energised before the delay");
  a_mute_action: assert property ( // RULE14
    s_mute_taken |-> (alarm_muted && mute_mask == hot && !live_relay))
    else $error("Mute did not take effect");
  a_stop_limit: assert property ( // RULE19
    (!stopped && shut_cnt == L_STOP) |=> stopped ##1
      (out_o.stop_relay == ($past(test_st) == hbac_pkg::TS_INV)))
    else $error("Stop not taken at the limit");
  a_timer_down: assert property ( // RULE21
    (!alarm && !stopped && tick) |=>
      (shut_cnt == (($past(shut_cnt) == '0) ? '0 : $past(shut_cnt) - 1'b1)))
    else $error("Shutdown timer not counting down to zero");
  a_restart: assert property ( // RULE23
    s_stop_then_cool |=> s_restored)
    else $error("Relays not restored after cooling");
  a_test_norm: assert property ( // RULE4
    (test_st == hbac_pkg::TS_NORM) |=> ((out_o.zone_lamp | M_TA) == '1 && out_o.alarm_lamp))
    else $error("Normal test does not light all lamps");
  a_test_invert: assert property ( // RULE6
    (test_st == hbac_pkg::TS_INV) |=>
      (out_o.stop_relay == !$past(live_stop) && out_o.alarm_relay == !$past(live_relay)))
    else $error("Relays not inverted in extended test");
  a_touch_filter: assert property ( // RULE8
    $rose(touch_act[hbac_pkg::BTN_TEST]) |-> (touch_cnt[hbac_pkg::BTN_TEST] == L_IGN))
    else $error("Touch accepted before the ignore time");
endmodule // hbac_top
`default_nettype wire

/* File: bench/hbac_field.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Field side: sensor chains, pads, remote mute
// ****************************************
module hbac_field (
  input  wire logic [7:0] hot_i,
  input  wire logic [7:0] used_i,
  input  wire logic       tst_i,
  input  wire logic       mut_i,
  input  wire logic       rem_i,
  output logic [7:0]      zone_o,
  output logic            tst_o,
  output logic            mut_o,
  output logic            rem_o
);
  // Unused chains are tied to supply; a hot chain opens and reads low
  assign zone_o = ~used_i | ~hot_i;
  assign tst_o  = tst_i;
  assign mut_o  = mut_i;
  assign rem_o  = rem_i;
endmodule // hbac_field
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic                core_clk_i;
  logic                rst_i;
  logic                tst;
  logic                mut;
  logic                rem;
  logic                t_i;
  logic                m_i;
  logic                r_i;
  logic [7:0]          hot;
  logic [7:0]          used;
  logic [7:0]          zone;
  logic [7:0]          mask;
  logic [31:0]         seed;
  hbac_pkg::hbac_out_t out;
  hbac_pkg::hbac_out_t ones;
  hbac_pkg::hbac_out_t zeros;
  int                  errors;
  int                  compares;
  int                  cycles;

  hbac_field field (.hot_i(hot), .used_i(used), .tst_i(tst), .mut_i(mut), .rem_i(rem),
                    .zone_o(zone), .tst_o(t_i), .mut_o(m_i), .rem_o(r_i));
  // Short tick, touch, delay, stop and blink keep the run short; other times are defaults
  // Alarm delay must stay below the stop time, or every alarm would end in a stop
  hbac_top #(.MS_CYCLES(2), .TOUCH_IGN_MS(5), .ALARM_DLY_MS(20), .STOP_MS(200),
    .BLINK_MS(5)) DUT (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .zone_level_i(zone), .remote_mute_i(r_i), .touch_test_i(t_i),
    .touch_mute_i(m_i), .out_o(out));

  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  task automatic chk(input string w, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", w, e, s);
    end
  endtask

  // Flashing shows as a bit seen both high and low over a few blink halves
  task automatic watch(input int n);
    ones = '0;
    zeros = '0;
    repeat (n) begin
      @(negedge core_clk_i);
      ones = hbac_pkg::hbac_out_t'(ones | out);
      zeros = hbac_pkg::hbac_out_t'(zeros | ~out);
    end
  endtask

  task automatic complete_run();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 50000) begin
      errors++;
      complete_run();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 32'hcf92;
    errors = 0;
    compares = 0;
    cycles = 0;
    rst_i = 1'b1;
    hot = 8'h00;
    used = 8'h7f;
    tst = 1'b0;
    mut = 1'b0;
    rem = 1'b0;
    cyc(3);
    rst_i = 1'b0;
    cyc(20);
    chk("idle", {3'h0, out}, {3'h0, hbac_pkg::OUT_RST});
    for (int i = 0; i < 6; i++) begin
      mask = 8'(rnd()) | 8'h01;
      hot = mask;
      cyc(20);
      chk("lamps", out.zone_lamp, mask & used);
      chk("alarm lamp", out.alarm_lamp, 1'b1);
      chk("early relay", out.alarm_relay, 1'b0);
      cyc(60);
      chk("relay", out.alarm_relay, 1'b1);
      hot = mask & 8'hfe;
      cyc(20);
      chk("part lamps", out.zone_lamp, hot & used);
      chk("part relay", out.alarm_relay, |(hot & used));
      hot = 8'h00;
      cyc(100);
      chk("cold", {out.zone_lamp, out.alarm_lamp, out.alarm_relay}, 16'h0);
    end
    $display("test alarms done");
    used = 8'hff;
    mask = (8'(rnd()) & 8'h7f) | 8'h01;
    hot = mask;
    cyc(60);
    rem = 1'b1;
    cyc(20);
    chk("muted relay", out.alarm_relay, 1'b0);
    watch(30);
    chk("muted lamps", ones.zone_lamp & zeros.zone_lamp, mask);
    chk("muted alarm", ones.alarm_lamp & zeros.alarm_lamp, 1'b1);
    rem = 1'b0;
    hot = mask | 8'h80;
    cyc(20);
    watch(30);
    chk("old lamps", ones.zone_lamp & zeros.zone_lamp, mask);
    chk("new lamp", {zeros.zone_lamp[7], zeros.alarm_lamp}, 16'h0);
    cyc(20);
    chk("relay back", out.alarm_relay, 1'b1);
    mut = 1'b1;
    cyc(18);
    chk("mute led", out.mute_led, 1'b1);
    chk("remuted", out.alarm_relay, 1'b0);
    mut = 1'b0;
    cyc(6);
    chk("led off", out.mute_led, 1'b0);
    watch(30);
    chk("all flash", ones.zone_lamp & zeros.zone_lamp, mask | 8'h80);
    hot = 8'h80;
    cyc(20);
    watch(30);
    chk("cooled off", ones.zone_lamp, 8'h80);
    hot = 8'h00;
    cyc(400);
    mut = 1'b1;
    watch(6);
    mut = 1'b0;
    chk("short touch", ones.mute_led, 1'b0);
    cyc(10);
    mut = 1'b1;
    cyc(4030);
    chk("auto off", out.mute_led, 1'b0);
    mut = 1'b0;
    $display("test mute done");
    mask = 8'(rnd()) | 8'h01;
    hot = mask;
    cyc(300);
    hot = 8'h00;
    cyc(100);
    chk("no stop", out.stop_relay, 1'b1);
    hot = mask;
    cyc(160);
    chk("down count", out.stop_relay, 1'b1);
    cyc(80);
    chk("stopped", out.stop_relay, 1'b0);
    watch(30);
    chk("stop lamps", ones.zone_lamp & zeros.zone_lamp, mask);
    hot = 8'h00;
    cyc(20);
    chk("restart", {out.zone_lamp, out.alarm_relay, out.stop_relay}, 16'h1);
    cyc(20);
    $display("test shutdown done");
    tst = 1'b1;
    cyc(14);
    chk("test led", out.test_led, 1'b1);
    watch(20);
    chk("hold flash", ones.zone_lamp & zeros.zone_lamp, 8'h40);
    tst = 1'b0;
    cyc(4);
    watch(20);
    chk("norm flash", ones.zone_lamp & zeros.zone_lamp, 8'h40);
    chk("norm lit", {zeros.zone_lamp & 8'hbf, zeros.alarm_lamp}, 16'h0);
    cyc(10000);
    chk("norm end", {out.zone_lamp, out.alarm_lamp}, 16'h0);
    tst = 1'b1;
    cyc(34);
    tst = 1'b0;
    cyc(10);
    tst = 1'b1;
    cyc(14);
    tst = 1'b0;
    cyc(16);
    watch(20);
    chk("ext flash", ones.zone_lamp & zeros.zone_lamp, 8'hc0);
    cyc(15990);
    chk("inverted", {out.alarm_relay, out.stop_relay}, 16'h2);
    watch(40);
    chk("inv flash", {ones.zone_lamp & zeros.zone_lamp, ones.alarm_lamp & zeros.alarm_lamp},
        9'h181);
    cyc(5960);
    chk("restored", {out.zone_lamp, out.alarm_relay, out.stop_relay}, 16'h1);
    $display("test self test done");
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
